// *** dio24_pkg.sv ***
package dio24_pkg;

  // Register offsets inside the I/O window
  localparam logic [3:0] OFS_FIRST_PORT_DATA  = 4'h0;
  localparam logic [3:0] OFS_SECOND_PORT_DATA = 4'h1;
  localparam logic [3:0] OFS_THIRD_PORT_DATA  = 4'h2;
  localparam logic [3:0] OFS_PORT_DIRECTION   = 4'h3;
  localparam logic [3:0] OFS_LINE_BIAS        = 4'h8;
  localparam logic [3:0] OFS_TOGGLE_IRQ_EN    = 4'hb;
  localparam logic [3:0] OFS_ALL_IRQ_DISABLE  = 4'hd;
  localparam logic [3:0] OFS_EDGE_IRQ_EN      = 4'he;
  localparam logic [3:0] OFS_PENDING_CLEAR    = 4'hf;

  // Direction register field positions (1 = input)
  localparam int unsigned DIR_THIRD_LOW_BIT  = 0;
  localparam int unsigned DIR_SECOND_BIT     = 1;
  localparam int unsigned DIR_THIRD_HIGH_BIT = 3;
  localparam int unsigned DIR_FIRST_BIT      = 4;
  localparam int unsigned DIR_SET_FLAG_BIT   = 7;
  localparam logic [7:0]  DIR_USED_MASK      = 8'h1b;
  localparam logic [7:0]  DIR_RESET          = 8'h1b;

  // Third port line 3 sits at bit 19 of the 24-line bus
  localparam int unsigned THIRD_LINE3_POS = 19;

  // Edge enable field positions
  localparam int unsigned EDGE_THIRD_LINE3_BIT = 0;
  localparam int unsigned EDGE_COUNTER_BIT     = 1;

  // Reset and default values
  localparam logic [3:0] BIAS_DEFAULT      = 4'hf;
  localparam logic [2:0] TOGGLE_EN_RESET   = 3'h7;
  localparam logic [1:0] EDGE_EN_RESET     = 2'h0;
  localparam logic [7:0] READ_ZERO         = 8'h00;

  // Port write masks over the 24-line bus
  localparam logic [23:0] MASK_FIRST  = 24'h0000ff;
  localparam logic [23:0] MASK_SECOND = 24'h00ff00;
  localparam logic [23:0] MASK_THIRD  = 24'hff0000;
  localparam logic [23:0] MASK_NONE   = 24'h000000;

endpackage

// *** dio24_sync.sv ***
`timescale 1ns/1ps
module dio24_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  // Two-stage synchroniser; only the second stage leaves this module
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule

// *** dio24_port_irq_block.sv ***
`timescale 1ns/1ps
// Function
// - Offset 0 reads first port lines; writes latch byte driven on them.
// - Offset 1 reads second port lines; writes latch byte driven on them.
// - Third port at offset 2 splits into two nibbles with own direction.
// - A port set to output reads back the value it is driving.
// - After reset all 24 lines are inputs, nothing driven.
// - Direction bits: 0 third low, 1 second, 3 third high, 4 first; 1=input.
// - Direction readback shows zero in bits 2, 5, 6 and 7.
// - Data writes accepted while input; last value driven on switch to output.
// - Never-written port drives its sampled input levels when turned output.
// - Offset 8 selects bias per group: 1 pull-up, 0 pull-down; upper ignored.
// - Bias kept in non-volatile store, restored at power-up, default pull-up.
// - Offset B: active-low toggle enables per port, bits 7..3 read zero.
// - Any line toggle on an enabled port raises an interrupt.
// - All interrupt sources start disabled after reset.
// - Low external enable pin blocks all sources; pin idles high.
// - Any write to offset D disables every interrupt source.
// - Offset E bit 0 enables interrupt on third port line 3 rising edge.
// - Offset E bit 1 enables interrupt on counter output rising edge.
// - Any write to offset F clears pending interrupts.
module dio24_port_irq_block (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o,
  input  wire logic [23:0] line_in_i,
  output logic      [23:0] line_out_o,
  output logic      [23:0] line_oe_o,
  output logic      [3:0]  bias_pullup_o,
  input  wire logic        nv_valid_i,
  input  wire logic [3:0]  nv_bias_i,
  output logic             nv_we_o,
  output logic      [3:0]  nv_wdata_o,
  input  wire logic        irq_enable_pin_i,
  input  wire logic        counter_out_i,
  output logic             irq_o
);
  import dio24_pkg::*;

  // Expand four group bits (first, second, third low, third high) to 24 lines
  function automatic logic [23:0] expand_grp(input logic [3:0] g);
    expand_grp = {{4{g[3]}}, {4{g[2]}}, {8{g[1]}}, {8{g[0]}}};
  endfunction

  // Reorder direction register bits into group order
  function automatic logic [3:0] dir_to_grp(input logic [7:0] d);
    dir_to_grp = {d[DIR_THIRD_HIGH_BIT], d[DIR_THIRD_LOW_BIT],
                  d[DIR_SECOND_BIT], d[DIR_FIRST_BIT]};
  endfunction

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction

  logic [1:0]  rst_sync_r;
  logic        rst_n;
  logic [23:0] line_s;
  logic [23:0] line_p_r;
  logic        cnt_s;
  logic        cnt_p_r;
  logic        irq_pin_s;
  logic [7:0]  dir_r;
  logic [7:0]  dir_nxt;
  logic [3:0]  written_r;
  logic [3:0]  written_nxt;
  logic [23:0] data_nxt;
  logic [3:0]  bias_nxt;
  logic        bias_loaded_r;
  logic [2:0]  tog_en_r;
  logic [2:0]  tog_en_nxt;
  logic [1:0]  edge_en_r;
  logic [1:0]  edge_en_nxt;
  logic        pending_nxt;
  logic [7:0]  rdata_nxt;

  // Reset release through two flops; assertion is immediate
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Field lines, counter output and enable pin enter through synchronisers
  dio24_sync #(.W(26)) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .d_i     ({irq_enable_pin_i, counter_out_i, line_in_i}),
    .q_o     ({irq_pin_s, cnt_s, line_s})
  );

  // Address decode
  wire wr_first  = wr_i && (addr_i == OFS_FIRST_PORT_DATA);
  wire wr_second = wr_i && (addr_i == OFS_SECOND_PORT_DATA);
  wire wr_third  = wr_i && (addr_i == OFS_THIRD_PORT_DATA);
  wire wr_dir    = wr_i && (addr_i == OFS_PORT_DIRECTION);
  wire wr_bias   = wr_i && (addr_i == OFS_LINE_BIAS);
  wire wr_tog    = wr_i && (addr_i == OFS_TOGGLE_IRQ_EN);
  wire wr_alloff = wr_i && (addr_i == OFS_ALL_IRQ_DISABLE);
  wire wr_edge   = wr_i && (addr_i == OFS_EDGE_IRQ_EN);
  wire wr_clear  = wr_i && (addr_i == OFS_PENDING_CLEAR);

  // Direction only changes when the set flag accompanies the write
  wire dir_take = wr_dir && wdata_i[DIR_SET_FLAG_BIT];
  assign dir_nxt = dir_take ? (wdata_i & DIR_USED_MASK) : dir_r;

  wire [3:0]  dir_grp   = dir_to_grp(dir_r);
  wire [23:0] dir_in_w  = expand_grp(dir_grp);
  wire [3:0]  wr_grp    = {wr_third, wr_third, wr_second, wr_first};
  wire [23:0] wr_mask   = wr_first  ? MASK_FIRST  :
                          wr_second ? MASK_SECOND :
                          wr_third  ? MASK_THIRD  : MASK_NONE;
  wire [23:0] wr_rep    = {wdata_i, wdata_i, wdata_i};

  // Untouched input groups follow their pins so the later switch is glitch-free
  wire [23:0] track_mask = expand_grp(dir_grp & ~written_r);

  assign written_nxt = written_r | wr_grp;
  assign data_nxt = (wr_rep & wr_mask)
                  | (line_s & track_mask & ~wr_mask)
                  | (line_out_o & ~track_mask & ~wr_mask);

  // Port data, written flags, direction and drive enables
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dir_r      <= DIR_RESET;
      written_r  <= 4'h0;
      line_out_o <= MASK_NONE;
      line_oe_o  <= MASK_NONE;
    end else begin
      dir_r      <= dir_nxt;
      written_r  <= written_nxt;
      line_out_o <= data_nxt;
      line_oe_o  <= ~expand_grp(dir_to_grp(dir_nxt));
    end
  end

  // Bias: reset shows pull-up, the stored copy is picked up one cycle later
  assign bias_nxt = wr_bias        ? wdata_i[3:0] :
                    !bias_loaded_r ? (nv_valid_i ? nv_bias_i : BIAS_DEFAULT) :
                    bias_pullup_o;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bias_loaded_r <= 1'b0;
      bias_pullup_o <= BIAS_DEFAULT;
      nv_we_o       <= 1'b0;
      nv_wdata_o    <= BIAS_DEFAULT;
    end else begin
      bias_loaded_r <= 1'b1;
      bias_pullup_o <= bias_nxt;
      nv_we_o       <= wr_bias;
      nv_wdata_o    <= wr_bias ? wdata_i[3:0] : nv_wdata_o;
    end
  end

  // Event detection on synchronised samples
  wire [2:0] tog_ev = {|(line_s[23:16] ^ line_p_r[23:16]),
                       |(line_s[15:8]  ^ line_p_r[15:8]),
                       |(line_s[7:0]   ^ line_p_r[7:0])};
  wire c3_rise  = rise(line_s[THIRD_LINE3_POS], line_p_r[THIRD_LINE3_POS]);
  wire cnt_rise = rise(cnt_s, cnt_p_r);

  // A low enable pin masks every source
  wire event_any = irq_pin_s && (
                     (|(tog_ev & ~tog_en_r))
                   || (c3_rise  && edge_en_r[EDGE_THIRD_LINE3_BIT])
                   || (cnt_rise && edge_en_r[EDGE_COUNTER_BIT]));

  // A write to the disable offset overrides any enable write in the same cycle
  assign tog_en_nxt  = wr_alloff ? TOGGLE_EN_RESET :
                       wr_tog    ? wdata_i[2:0] : tog_en_r;
  assign edge_en_nxt = wr_alloff ? EDGE_EN_RESET :
                       wr_edge   ? wdata_i[1:0] : edge_en_r;

  // New event beats a clear arriving in the same cycle
  assign pending_nxt = event_any | (irq_o & ~wr_clear);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      line_p_r  <= MASK_NONE;
      cnt_p_r   <= 1'b0;
      tog_en_r  <= TOGGLE_EN_RESET;
      edge_en_r <= EDGE_EN_RESET;
      irq_o     <= 1'b0;
    end else begin
      line_p_r  <= line_s;
      cnt_p_r   <= cnt_s;
      tog_en_r  <= tog_en_nxt;
      edge_en_r <= edge_en_nxt;
      irq_o     <= pending_nxt;
    end
  end

  // Inputs show pins, outputs show the driven value
  wire [23:0] port_rd = (dir_in_w & line_s) | (~dir_in_w & line_out_o);

  always_comb begin
    case (addr_i)
      OFS_FIRST_PORT_DATA:  rdata_nxt = port_rd[7:0];
      OFS_SECOND_PORT_DATA: rdata_nxt = port_rd[15:8];
      OFS_THIRD_PORT_DATA:  rdata_nxt = port_rd[23:16];
      OFS_PORT_DIRECTION:   rdata_nxt = dir_r & DIR_USED_MASK;
      OFS_TOGGLE_IRQ_EN:    rdata_nxt = {5'h00, tog_en_r};
      OFS_EDGE_IRQ_EN:      rdata_nxt = {6'h00, edge_en_r};
      default:              rdata_nxt = READ_ZERO;
    endcase
  end

  // Read data is captured on the read strobe and held until the next one
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= READ_ZERO;
    end else if (rd_i) begin
      rdata_o <= rdata_nxt;
    end
  end

  AST_RD_FIRST_OUT: assert property (@(posedge clk_i) disable iff (!rst_n)
    (rd_i && addr_i == OFS_FIRST_PORT_DATA && !dir_r[DIR_FIRST_BIT])
      |=> rdata_o == $past(line_out_o[7:0]))
    else $error("first port readback differs from driven value");

  AST_RD_SECOND_IN: assert property (@(posedge clk_i) disable iff (!rst_n)
    (rd_i && addr_i == OFS_SECOND_PORT_DATA && dir_r[DIR_SECOND_BIT])
      |=> rdata_o == $past(line_s[15:8]))
    else $error("second port read does not show pins");

  AST_WR_THIRD: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_third |=> line_out_o[23:16] == $past(wdata_i))
    else $error("third port write not latched");

  AST_DIR_RB: assert property (@(posedge clk_i) disable iff (!rst_n)
    (rd_i && addr_i == OFS_PORT_DIRECTION) |=> (rdata_o[7:5] == 3'h0 && !rdata_o[2]))
    else $error("direction reserved bits read nonzero");

  AST_DIR_NOFLAG: assert property (@(posedge clk_i) disable iff (!rst_n)
    (wr_dir && !wdata_i[DIR_SET_FLAG_BIT]) |=> $stable(line_oe_o))
    else $error("direction changed without set flag");

  AST_DIR_FIRST: assert property (@(posedge clk_i) disable iff (!rst_n)
    dir_take |=> line_oe_o[7:0] == {8{~$past(wdata_i[DIR_FIRST_BIT])}})
    else $error("first port enable mismatches direction");

  AST_TRACK: assert property (@(posedge clk_i) disable iff (!rst_n)
    (dir_r[DIR_FIRST_BIT] && !written_r[0] && !wr_first)
      |=> line_out_o[7:0] == $past(line_s[7:0]))
    else $error("unwritten first port not tracking pins");

  AST_PEND_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n)
    (irq_o && !wr_clear) |=> irq_o)
    else $error("pending request dropped without clear");

  AST_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n)
    (wr_clear && !event_any) |=> !irq_o)
    else $error("clear did not drop request");

  AST_PIN_GATE: assert property (@(posedge clk_i) disable iff (!rst_n)
    (!irq_pin_s && !irq_o) |=> !irq_o)
    else $error("request raised while enable pin low");

  AST_ALL_OFF: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_alloff |=> (!event_any && tog_en_r == TOGGLE_EN_RESET))
    else $error("sources still enabled after global disable");

  AST_BIAS: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_bias |=> (bias_pullup_o == $past(wdata_i[3:0]) && nv_we_o))
    else $error("bias write not applied");

  AST_C3_EDGE: assert property (@(posedge clk_i) disable iff (!rst_n)
    (irq_pin_s && edge_en_r[EDGE_THIRD_LINE3_BIT] && c3_rise) |=> irq_o)
    else $error("line 3 rising edge missed");

  AST_CNT_EDGE: assert property (@(posedge clk_i) disable iff (!rst_n)
    (irq_pin_s && edge_en_r[EDGE_COUNTER_BIT] && cnt_rise) |=> irq_o)
    else $error("counter rising edge missed");

  AST_TOGGLE: assert property (@(posedge clk_i) disable iff (!rst_n)
    (irq_pin_s && !tog_en_r[1] && (line_s[15:8] != line_p_r[15:8])) |=> irq_o)
    else $error("second port toggle missed");

  AST_UNUSED: assert property (@(posedge clk_i) disable iff (!rst_n)
    (rd_i && (addr_i == 4'h5 || addr_i == 4'hc || addr_i == OFS_PENDING_CLEAR))
      |=> rdata_o == READ_ZERO)
    else $error("unused offset read nonzero");

  AST_WR_FIRST: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_first |=> line_out_o[7:0] == $past(wdata_i))
    else $error("first port write not latched");

  AST_WR_SECOND: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_second |=> line_out_o[15:8] == $past(wdata_i))
    else $error("second port write not latched");

  AST_NIBBLE_OE: assert property (@(posedge clk_i) disable iff (!rst_n)
    dir_take |=> (line_oe_o[19:16] == {4{~$past(wdata_i[DIR_THIRD_LOW_BIT])}}
              && line_oe_o[23:20] == {4{~$past(wdata_i[DIR_THIRD_HIGH_BIT])}}))
    else $error("third port nibble enables mismatch direction");

  AST_RD_THIRD_OUT: assert property (@(posedge clk_i) disable iff (!rst_n)
    (rd_i && addr_i == OFS_THIRD_PORT_DATA && !dir_r[DIR_THIRD_HIGH_BIT])
      |=> rdata_o[7:4] == $past(line_out_o[23:20]))
    else $error("third port high nibble readback differs from driven value");

  AST_RESET_IN: assert property (@(posedge clk_i)
    !rst_n |-> line_oe_o == MASK_NONE)
    else $error("line driven during reset");

  AST_WR_KEEP: assert property (@(posedge clk_i) disable iff (!rst_n)
    (written_r[0] && !wr_first) |=> $stable(line_out_o[7:0]))
    else $error("written first port value not kept");

  AST_NV_LOAD: assert property (@(posedge clk_i) disable iff (!rst_n)
    (!bias_loaded_r && !wr_bias)
      |=> bias_pullup_o == ($past(nv_valid_i) ? $past(nv_bias_i) : BIAS_DEFAULT))
    else $error("stored bias not restored after reset");

  AST_TOG_RB: assert property (@(posedge clk_i) disable iff (!rst_n)
    (rd_i && addr_i == OFS_TOGGLE_IRQ_EN) |=> rdata_o[7:3] == 5'h00)
    else $error("toggle enable upper bits read nonzero");

  AST_SRC_OFF: assert property (@(posedge clk_i) disable iff (!rst_n)
    !bias_loaded_r |-> (tog_en_r == TOGGLE_EN_RESET && edge_en_r == EDGE_EN_RESET
                        && !irq_o))
    else $error("interrupt source enabled at reset release");

  AST_EDGE_RB: assert property (@(posedge clk_i) disable iff (!rst_n)
    (rd_i && addr_i == OFS_EDGE_IRQ_EN) |=> rdata_o[7:2] == 6'h00)
    else $error("edge enable upper bits read nonzero");

  AST_SET_WINS: assert property (@(posedge clk_i) disable iff (!rst_n)
    (wr_clear && event_any) |=> irq_o)
    else $error("same-cycle event lost to clear");

  AST_SYNC_CNT: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(cnt_s) |-> $past(counter_out_i, 2))
    else $error("counter edge seen without synchroniser delay");

endmodule

// *** field_partner.sv ***
`timescale 1ns/1ps
module field_partner (
  input  wire logic        clk_i,
  input  wire logic [23:0] line_out_i,
  input  wire logic [23:0] line_oe_i,
  input  wire logic [3:0]  bias_pullup_i,
  input  wire logic [23:0] ext_val_i,
  input  wire logic [23:0] ext_en_i,
  input  wire logic        nv_we_i,
  input  wire logic [3:0]  nv_wdata_i,
  output logic      [23:0] line_o,
  output logic             nv_valid_o,
  output logic      [3:0]  nv_bias_o
);
  logic [23:0] pull_lvl;
  logic        stored_r = 1'b0;
  logic [3:0]  copy_r   = 4'h0;

  // Undriven lines settle to their group bias; device drive wins over field drive
  assign pull_lvl   = {{4{bias_pullup_i[3]}}, {4{bias_pullup_i[2]}},
                       {8{bias_pullup_i[1]}}, {8{bias_pullup_i[0]}}};
  assign line_o     = (line_oe_i & line_out_i) | (~line_oe_i & ext_en_i & ext_val_i)
                    | (~line_oe_i & ~ext_en_i & pull_lvl);
  assign nv_valid_o = stored_r;
  assign nv_bias_o  = copy_r;

  // Store survives device resets; blank until first write
  always @(posedge clk_i) begin
    if (nv_we_i) begin
      stored_r <= 1'b1;
      copy_r   <= nv_wdata_i;
    end
  end
endmodule

// *** dio24_port_irq_block_bench.sv ***
`timescale 1ns/1ps
module dio24_port_irq_block_bench;
  import dio24_pkg::*;
  logic        clk_i, arst_n_i, wr_i, rd_i, nv_we, nv_valid, irq_en, cnt, irq;
  logic [3:0]  addr_i, bias, nv_wdata, nv_bias;
  logic [7:0]  wdata_i, rdata;
  logic [23:0] line_in, line_out, line_oe, ext_val, ext_en;
  int          fails, n_checks;

  dio24_port_irq_block i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata), .line_in_i(line_in),
    .line_out_o(line_out), .line_oe_o(line_oe), .bias_pullup_o(bias),
    .nv_valid_i(nv_valid), .nv_bias_i(nv_bias), .nv_we_o(nv_we), .nv_wdata_o(nv_wdata),
    .irq_enable_pin_i(irq_en), .counter_out_i(cnt), .irq_o(irq));
  field_partner i_field (.clk_i(clk_i), .line_out_i(line_out), .line_oe_i(line_oe),
    .bias_pullup_i(bias), .ext_val_i(ext_val), .ext_en_i(ext_en), .nv_we_i(nv_we),
    .nv_wdata_i(nv_wdata), .line_o(line_in), .nv_valid_o(nv_valid), .nv_bias_o(nv_bias));

  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Strobes rise and fall on falling edges, so the rising edge sees them settled
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    @(negedge clk_i);
    wr_i = 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    addr_i = a;
    rd_i = 1'b1;
    @(negedge clk_i);
    rd_i = 1'b0;
    chk({16'h0, rdata}, {16'h0, exp});
  endtask

  // Bounded wait for the request line; running out ends the run
  task automatic wait_irq;
    int k;
    for (k = 0; k < 8 && irq !== 1'b1; k++) @(negedge clk_i);
    chk({23'h0, irq}, 24'h1);
    if (irq !== 1'b1) conclude();
  endtask

  task automatic do_reset;
    arst_n_i = 1'b0;
    idle(3);
    arst_n_i = 1'b1;
    idle(3);
  endtask

  task automatic t_reset;
    chk(line_oe, 24'h0);
    chk({20'h0, bias}, 24'hf);
    chk({23'h0, irq}, 24'h0);
    rd_chk(4'he, 8'h00);
    rd_chk(4'hb, 8'h07);
    rd_chk(4'h3, 8'h1b);
  endtask

  task automatic t_ports;
    ext_en = 24'hffffff;
    ext_val = 24'ha5c333;
    idle(3);
    rd_chk(4'h0, 8'h33);
    bus_wr(4'h0, 8'h5a);
    bus_wr(4'h1, 8'h3c);
    chk(line_oe, 24'h0);
    bus_wr(4'h3, 8'h8b);
    chk(line_oe, 24'h0000ff);
    chk({16'h0, line_out[7:0]}, 24'h5a);
    rd_chk(4'h3, 8'h0b);
    rd_chk(4'h0, 8'h5a);
    bus_wr(4'h3, 8'h13);
    chk(line_oe, 24'h0000ff);
    bus_wr(4'h3, 8'h93);
    chk(line_oe, 24'hf00000);
    chk({20'h0, line_out[23:20]}, 24'ha);
    rd_chk(4'h2, 8'ha5);
    bus_wr(4'h3, 8'h80);
    chk(line_oe, 24'hffffff);
    chk(line_out, 24'ha53c5a);
    rd_chk(4'h1, 8'h3c);
  endtask

  task automatic t_bias;
    bus_wr(4'h8, 8'hf5);
    chk({20'h0, bias}, 24'h5);
    rd_chk(4'h8, 8'h00);
    ext_en = 24'h0;
    do_reset();
    chk({20'h0, bias}, 24'h5);
    chk(line_oe, 24'h0);
    rd_chk(4'h0, 8'hff);
    rd_chk(4'h1, 8'h00);
    rd_chk(4'h2, 8'h0f);
  endtask

  task automatic t_irq;
    ext_en = 24'hffffff;
    ext_val = 24'h0;
    idle(4);
    ext_val[3] = 1'b1;
    idle(6);
    chk({23'h0, irq}, 24'h0);
    bus_wr(4'hb, 8'h06);
    rd_chk(4'hb, 8'h06);
    ext_val[9] = 1'b1;
    idle(6);
    chk({23'h0, irq}, 24'h0);
    ext_val[3] = 1'b0;
    wait_irq();
    idle(4);
    chk({23'h0, irq}, 24'h1);
    bus_wr(4'hf, 8'h00);
    chk({23'h0, irq}, 24'h0);
    irq_en = 1'b0;
    ext_val[3] = 1'b1;
    idle(6);
    chk({23'h0, irq}, 24'h0);
    irq_en = 1'b1;
    bus_wr(4'hb, 8'h07);
    bus_wr(4'he, 8'hfd);
    rd_chk(4'he, 8'h01);
    bus_wr(4'he, 8'h03);
    ext_val[19] = 1'b1;
    wait_irq();
    bus_wr(4'hf, 8'h00);
    ext_val[19] = 1'b0;
    idle(6);
    chk({23'h0, irq}, 24'h0);
    cnt = 1'b1;
    wait_irq();
    bus_wr(4'hf, 8'h00);
    bus_wr(4'hb, 8'h01);
    ext_val[9] = 1'b0;
    wait_irq();
    bus_wr(4'hf, 8'h00);
    ext_val[22] = 1'b1;
    wait_irq();
    irq_en = 1'b0;
    idle(4);
    chk({23'h0, irq}, 24'h1);
    irq_en = 1'b1;
    bus_wr(4'hf, 8'h00);
    bus_wr(4'hd, 8'h5a);
    rd_chk(4'he, 8'h00);
    rd_chk(4'hb, 8'h07);
    cnt = 1'b0;
    idle(3);
    cnt = 1'b1;
    ext_val[19] = 1'b1;
    idle(6);
    chk({23'h0, irq}, 24'h0);
  endtask

  // Unused and write-only places read zero; stray writes leave direction alone
  task automatic t_unused;
    logic [3:0] offs [7];
    offs = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'ha, 4'hc};
    foreach (offs[i]) begin
      bus_wr(offs[i], 8'hff);
      rd_chk(offs[i], 8'h00);
    end
    rd_chk(4'hd, 8'h00);
    rd_chk(4'hf, 8'h00);
    rd_chk(4'h3, 8'h1b);
  endtask

  // Main sequence; every input has a value at time zero
  initial begin
    fails = 0;
    n_checks = 0;
    {wr_i, rd_i, addr_i, wdata_i, cnt, ext_val, ext_en} = '0;
    irq_en = 1'b1;
    do_reset();
    t_reset();
    t_ports();
    t_bias();
    t_irq();
    t_unused();
    conclude();
  end
endmodule
